//--- rtl/pesr_bridge.sv
// pci bridge error status, command selection, trdy timeout and retry logic
`timescale 1ns/10ps

// Function
// - target abort sent sets status bit 11
// - received target abort sets status bit 12
// - non-special master abort sets status bit 13
// - address parity error drives serr, sets 14
// - any parity error sets 15; irq gated
// - flags clear by writing one; raise irq
// - latency timer; zero forbids bursts
// - latency timer low two bits read zero
// - eight-bit line size, resets to zero
// - read command chosen from transfer length
// - line size decides write invalidate use
// - invalidate needs enable, alignment, full line
// - trdy wait over limit aborts, flags
// - timed-out read returns bus error
// - first read attempts equal retry limit
// - drain writes and returns before retrying
// - further attempts by interface revision
// - final read failure aborts with error
// - write retried to limit then discarded
// - trdy flag only when its enable set
// - retry flag only when its enable set
module pesr_bridge
(
    input  wire logic              mclk,
    input  wire logic              rst_b,
    // register port
    input  wire logic [7:0]        regAddr,
    input  wire logic [31:0]       regWrData,
    input  wire logic              regWr,
    input  wire logic              regRd,
    output logic [31:0]            regRdData,
    // pci pins
    input  wire logic              pciClk,
    input  wire logic              trdyPin_b,
    output logic                   serrPinOut,
    output logic                   serrPinOe_b,
    // events from the pci protocol engine
    input  wire logic              evTargetAbortSent,
    input  wire logic              evTargetAbortRcvd,
    input  wire logic              evMasterAbort,
    input  wire logic              evSpecialCycle,
    input  wire logic              evAddrParErr,
    input  wire logic              evDataParErr,
    // internal requester
    input  wire logic              reqValid,
    input  wire pesr_pkg::pesr_req_t reqData,
    output logic                   reqReady,
    output logic                   rspValid,
    output pesr_pkg::pesr_rsp_t    rspData,
    // master command to the pci protocol engine
    output logic                   cmdValid,
    output pesr_pkg::pesr_cmd_t    cmdData,
    input  wire logic              xferDone,
    input  wire logic              xferDisc,
    input  wire logic [31:0]       xferData,
    input  wire logic              drainIdle,
    output logic                   pciErrInt
);
    import pesr_pkg::*;

    // ======================================================================
    // functions
    function automatic logic [3:0] pick_cmd(input pesr_req_t r, input logic [7:0] line,
                                            input logic winvEn);
        logic [15:0] lineW;
        logic [16:0] twoLines;
        logic        aligned;
        lineW    = {8'h00, line};
        twoLines = {8'h00, line, 1'b0};
        aligned  = (line != 8'h00) && ((r.addr[17:2] % lineW) == 16'h0000);
        if (r.write)
        begin
            if (winvEn && aligned && (r.words >= lineW))
                pick_cmd = CMD_MEM_WR_INV;
            else
                pick_cmd = CMD_MEM_WRITE;
        end
        else if (line == 8'h00 || r.words < lineW)
            pick_cmd = CMD_MEM_READ;
        else if ({1'b0, r.words} >= twoLines)
            pick_cmd = CMD_MEM_READ_MUL;
        else
            pick_cmd = CMD_MEM_READ_LN;
    endfunction : pick_cmd

    function automatic logic w1c(input logic flag, input logic set, input logic clr);
        // a set in the clearing cycle wins
        w1c = (flag & ~clr) | set;
    endfunction : w1c

    // ======================================================================
    // pin synchronisers
    logic pciClkS1_reg;
    logic pciClkS2_reg;
    logic pciClkS3_reg;
    logic trdyS1_reg;
    logic trdyS2_reg;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pciClkS1_reg <= 1'b0;
            pciClkS2_reg <= 1'b0;
            pciClkS3_reg <= 1'b0;
            trdyS1_reg   <= 1'b1;
            trdyS2_reg   <= 1'b1;
        end
        else
        begin
            pciClkS1_reg <= pciClk;
            pciClkS2_reg <= pciClkS1_reg;
            pciClkS3_reg <= pciClkS2_reg;
            trdyS1_reg   <= trdyPin_b;
            trdyS2_reg   <= trdyS1_reg;
        end
    end

    wire pciRise      = pciClkS2_reg & ~pciClkS3_reg;
    wire trdyAsserted = ~trdyS2_reg;

    // ======================================================================
    // registers
    logic       sigTgtAbort_reg;
    logic       rcvTgtAbort_reg;
    logic       masterAbort_reg;
    logic       serrDriven_reg;
    logic       parSeen_reg;
    logic       trdyTimeoutFlag_reg;
    logic       retryFlag_reg;
    logic [7:0] lineSize_reg;
    logic [5:0] burstTimer_reg;
    logic [7:0] waitLimit_reg;
    logic [7:0] retryLimit_reg;
    logic       parRespEn_reg;
    logic       winvEn_reg;
    logic       target_ready_timeout_int_enable_reg;
    logic       retry_exhausted_int_enable_reg;
    logic [3:0] ifRev_reg;
    logic [7:0] bypassCnt_reg;
    logic       serrDrive_reg;

    wire wrStatus = regWr && (regAddr == ADDR_STATUS);
    wire wrLine   = regWr && (regAddr == ADDR_LINE);
    wire wrLimits = regWr && (regAddr == ADDR_LIMITS);
    wire wrCtrl   = regWr && (regAddr == ADDR_CTRL);
    wire wrErr    = regWr && (regAddr == ADDR_ERR);

    wire [15:0] stClr = wrStatus ? regWrData[31:16] : 16'h0000;
    wire [31:0] erClr = wrErr ? regWrData : 32'h0000_0000;

    // timeout and retry events from the sequencer
    logic trdyTimeoutEv;
    logic retryExhaustEv;

    wire parAny = evAddrParErr | evDataParErr;

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sigTgtAbort_reg     <= 1'b0;
            rcvTgtAbort_reg     <= 1'b0;
            masterAbort_reg     <= 1'b0;
            serrDriven_reg      <= 1'b0;
            parSeen_reg         <= 1'b0;
            trdyTimeoutFlag_reg <= 1'b0;
            retryFlag_reg       <= 1'b0;
        end
        else
        begin
            sigTgtAbort_reg <= w1c(sigTgtAbort_reg, evTargetAbortSent,
                                   stClr[BIT_SIG_TABORT]);
            rcvTgtAbort_reg <= w1c(rcvTgtAbort_reg, evTargetAbortRcvd,
                                   stClr[BIT_RCV_TABORT]);
            masterAbort_reg <= w1c(masterAbort_reg, evMasterAbort & ~evSpecialCycle,
                                   stClr[BIT_MABORT]);
            serrDriven_reg  <= w1c(serrDriven_reg, evAddrParErr,
                                   stClr[BIT_SERR_DRIVEN]);
            parSeen_reg     <= w1c(parSeen_reg, parAny, stClr[BIT_PAR_SEEN]);
            trdyTimeoutFlag_reg <= w1c(trdyTimeoutFlag_reg,
                                       trdyTimeoutEv & target_ready_timeout_int_enable_reg,
                                       erClr[ERR_TRDY]);
            retryFlag_reg   <= w1c(retryFlag_reg, retryExhaustEv & retry_exhausted_int_enable_reg,
                                   erClr[ERR_RETRY]);
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            lineSize_reg   <= LINE_SIZE_RST;
            burstTimer_reg <= BURST_TIMER_RST[7:2];
            waitLimit_reg  <= WAIT_LIMIT_RST;
            retryLimit_reg <= RETRY_LIMIT_RST;
        end
        else
        begin
            if (wrLine)
            begin
                lineSize_reg   <= regWrData[LINE_SIZE_LSB +: 8];
                burstTimer_reg <= regWrData[BURST_TIMER_LSB + 2 +: 6];
            end
            if (wrLimits)
            begin
                waitLimit_reg  <= regWrData[WAIT_LIMIT_LSB +: 8];
                retryLimit_reg <= regWrData[RETRY_LIMIT_LSB +: 8];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            parRespEn_reg  <= 1'b0;
            winvEn_reg     <= 1'b0;
            target_ready_timeout_int_enable_reg  <= 1'b0;
            retry_exhausted_int_enable_reg <= 1'b0;
            ifRev_reg      <= REV_RST;
            bypassCnt_reg  <= BYPASS_RST;
        end
        else if (wrCtrl)
        begin
            parRespEn_reg  <= regWrData[CTRL_PAR_RESP];
            winvEn_reg     <= regWrData[CTRL_WINV_EN];
            target_ready_timeout_int_enable_reg  <= regWrData[CTRL_TRDY_IEN];
            retry_exhausted_int_enable_reg <= regWrData[CTRL_RETRY_IEN];
            ifRev_reg      <= regWrData[CTRL_REV_LSB +: 4];
            bypassCnt_reg  <= regWrData[CTRL_BYPASS_LSB +: 8];
        end
    end

    // ======================================================================
    // read path
    wire [15:0] statusUpper = {parSeen_reg, serrDriven_reg, masterAbort_reg,
                               rcvTgtAbort_reg, sigTgtAbort_reg, 11'h000};
    wire [7:0]  burstTimerRd = {burstTimer_reg, BURST_TIMER_RO};
    wire [31:0] ctrlRd = {16'h0000, bypassCnt_reg, ifRev_reg, retry_exhausted_int_enable_reg,
                          target_ready_timeout_int_enable_reg, winvEn_reg, parRespEn_reg};
    logic [31:0] rdMux;

    always_comb
    begin
        unique case (regAddr)
            ADDR_STATUS: rdMux = {statusUpper, 16'h0000};
            ADDR_LINE:   rdMux = {16'h0000, burstTimerRd, lineSize_reg};
            ADDR_LIMITS: rdMux = {16'h0000, retryLimit_reg, waitLimit_reg};
            ADDR_CTRL:   rdMux = ctrlRd;
            ADDR_ERR:    rdMux = {30'h0000_0000, retryFlag_reg, trdyTimeoutFlag_reg};
            default:     rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            regRdData <= 32'h0000_0000;
        else if (regRd)
            regRdData <= rdMux;
    end

    // ======================================================================
    // serr pin: held low until the next pci clock rising edge
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            serrDrive_reg <= 1'b0;
        else if (evAddrParErr)
            serrDrive_reg <= 1'b1;
        else if (pciRise)
            serrDrive_reg <= 1'b0;
    end

    assign serrPinOut  = 1'b0;
    assign serrPinOe_b = ~serrDrive_reg;

    // parity seen (bit 15) only reaches the interrupt with parity response enabled
    assign pciErrInt = sigTgtAbort_reg | rcvTgtAbort_reg | masterAbort_reg |
                       serrDriven_reg | (parSeen_reg & parRespEn_reg) |
                       trdyTimeoutFlag_reg | retryFlag_reg;

    // ======================================================================
    // master sequencer
    pesr_state_t state_reg;
    pesr_state_t state_next;
    pesr_req_t   req_reg;
    logic [8:0]  waitCnt_reg;
    logic [7:0]  attempts_reg;
    logic        secondPhase_reg;

    wire [8:0] waitInc    = waitCnt_reg + 9'h001;
    wire       waitExpire = pciRise && !trdyAsserted && (waitInc > {1'b0, waitLimit_reg});
    wire [7:0] attemptInc = attempts_reg + 8'h01;
    // further reads after draining depend on interface revision
    wire [7:0] secondLimit = (ifRev_reg < REV_MULTI_RETRY) ? LEGACY_RETRIES
                                                             : bypassCnt_reg;
    wire [7:0] phaseLimit  = secondPhase_reg ? secondLimit : retryLimit_reg;
    wire       attemptsOut = (attemptInc >= phaseLimit);
    wire       inWait      = (state_reg == ST_WAIT);
    wire       discFail    = inWait && xferDisc && !waitExpire;
    wire       finalFail   = discFail && attemptsOut &&
                             (req_reg.write || secondPhase_reg);
    wire       toDrain     = discFail && attemptsOut && !req_reg.write && !secondPhase_reg;

    assign trdyTimeoutEv  = inWait && waitExpire;
    assign retryExhaustEv = finalFail;
    assign reqReady       = (state_reg == ST_IDLE);
    assign cmdValid       = (state_reg == ST_ISSUE);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (reqValid)
                    state_next = ST_ISSUE;
            ST_ISSUE:
                state_next = ST_WAIT;
            ST_WAIT:
                if (waitExpire || xferDone || finalFail)
                    state_next = ST_IDLE;
                else if (toDrain)
                    state_next = ST_DRAIN;
                else if (discFail)
                    state_next = ST_ISSUE;
            ST_DRAIN:
                if (drainIdle)
                    state_next = ST_ISSUE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            state_reg <= ST_IDLE;
        else
            state_reg <= state_next;
    end

    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_reg         <= '0;
            attempts_reg    <= 8'h00;
            secondPhase_reg <= 1'b0;
        end
        else if (reqReady && reqValid)
        begin
            req_reg         <= reqData;
            attempts_reg    <= 8'h00;
            secondPhase_reg <= 1'b0;
        end
        else if (toDrain)
        begin
            attempts_reg    <= 8'h00;
            secondPhase_reg <= 1'b1;
        end
        else if (discFail)
            attempts_reg <= attemptInc;
    end

    // wait counter advances on pci clock edges with trdy still high
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            waitCnt_reg <= 9'h000;
        else if (!inWait || trdyAsserted)
            waitCnt_reg <= 9'h000;
        else if (pciRise)
            waitCnt_reg <= waitInc;
    end

    // command chosen once per request from the incoming reqData, reused by every retry
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
            cmdData <= '0;
        else if (state_reg == ST_IDLE && reqValid)
        begin
            cmdData.code    <= pick_cmd(reqData, lineSize_reg, winvEn_reg);
            cmdData.burstEn <= (burstTimer_reg != 6'h00);
            cmdData.addr    <= reqData.addr;
            cmdData.words   <= reqData.words;
        end
    end

    // ======================================================================
    // response to the internal requester
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rspValid <= 1'b0;
            rspData  <= '0;
        end
        else
        begin
            rspValid <= inWait && (xferDone || waitExpire || finalFail);
            if (inWait && (xferDone || waitExpire || finalFail))
            begin
                // on errors the data word carries whatever the engine last showed
                rspData.busErr    <= waitExpire || finalFail;
                rspData.discarded <= finalFail && req_reg.write;
                rspData.data      <= xferData;
            end
        end
    end

endmodule : pesr_bridge

//--- common/pesr_pkg.sv
// package: register map, field layout, reset values, commands and carrier types
package pesr_pkg;

    // ======================================================================
    // register map (byte addresses)
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LINE   = 8'h0C;
    localparam logic [7:0] ADDR_LIMITS = 8'h40;
    localparam logic [7:0] ADDR_CTRL   = 8'h88;
    localparam logic [7:0] ADDR_ERR    = 8'h8C;

    // ======================================================================
    // field positions inside the 32-bit words
    localparam int STAT_SHIFT      = 16;
    localparam int BIT_SIG_TABORT  = 11;
    localparam int BIT_RCV_TABORT  = 12;
    localparam int BIT_MABORT      = 13;
    localparam int BIT_SERR_DRIVEN = 14;
    localparam int BIT_PAR_SEEN    = 15;
    localparam int LINE_SIZE_LSB   = 0;
    localparam int BURST_TIMER_LSB = 8;
    localparam int WAIT_LIMIT_LSB  = 0;
    localparam int RETRY_LIMIT_LSB = 8;
    localparam int CTRL_PAR_RESP   = 0;
    localparam int CTRL_WINV_EN    = 1;
    localparam int CTRL_TRDY_IEN   = 2;
    localparam int CTRL_RETRY_IEN  = 3;
    localparam int CTRL_REV_LSB    = 4;
    localparam int CTRL_BYPASS_LSB = 8;
    localparam int ERR_TRDY        = 0;
    localparam int ERR_RETRY       = 1;

    // ======================================================================
    // reset values and fixed values
    localparam logic [7:0] LINE_SIZE_RST   = 8'h00;
    localparam logic [7:0] BURST_TIMER_RST = 8'h00;
    localparam logic [1:0] BURST_TIMER_RO  = 2'h0;
    localparam logic [7:0] WAIT_LIMIT_RST  = 8'h80;
    localparam logic [7:0] RETRY_LIMIT_RST = 8'h80;
    localparam logic [3:0] REV_RST         = 4'h3;
    localparam logic [7:0] BYPASS_RST      = 8'h01;
    localparam logic [3:0] REV_MULTI_RETRY = 4'h3;
    localparam logic [7:0] LEGACY_RETRIES  = 8'h01;

    // ======================================================================
    // bus commands
    localparam logic [3:0] CMD_MEM_READ     = 4'h6;
    localparam logic [3:0] CMD_MEM_READ_LN  = 4'hE;
    localparam logic [3:0] CMD_MEM_READ_MUL = 4'hC;
    localparam logic [3:0] CMD_MEM_WRITE    = 4'h7;
    localparam logic [3:0] CMD_MEM_WR_INV   = 4'hF;

    // ======================================================================
    // carrier types
    typedef struct packed {
        logic        write;
        logic [31:0] addr;
        logic [15:0] words;
    } pesr_req_t;

    typedef struct packed {
        logic [3:0]  code;
        logic        burstEn;
        logic [31:0] addr;
        logic [15:0] words;
    } pesr_cmd_t;

    typedef struct packed {
        logic        busErr;
        logic        discarded;
        logic [31:0] data;
    } pesr_rsp_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ISSUE,
        ST_WAIT,
        ST_DRAIN
    } pesr_state_t;

endpackage : pesr_pkg

//--- tb/pesr_bridge_props.sv
// checker: port-level properties of the bridge
`timescale 1ns/10ps
module pesr_bridge_props
    import pesr_pkg::*;
(
    input wire logic                mclk,
    input wire logic                rst_b,
    input wire logic [7:0]          regAddr,
    input wire logic [31:0]         regWrData,
    input wire logic                regWr,
    input wire logic                serrPinOut,
    input wire logic                serrPinOe_b,
    input wire logic                evTargetAbortSent,
    input wire logic                evAddrParErr,
    input wire logic                reqValid,
    input wire logic                reqReady,
    input wire logic                rspValid,
    input wire pesr_pkg::pesr_rsp_t rspData,
    input wire logic                cmdValid,
    input wire pesr_pkg::pesr_cmd_t cmdData,
    input wire logic                xferDone,
    input wire logic                pciErrInt
);
    // ==================================================================
    // shadow of the line size and latency timer
    logic [7:0] lineSz_reg;
    logic [7:0] latV_reg;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
            {latV_reg, lineSz_reg} <= 16'h0000;
        else if (regWr && regAddr == ADDR_LINE)
            {latV_reg, lineSz_reg} <= {regWrData[15:10], 2'h0, regWrData[7:0]};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    // ==================================================================
    // assertions
    chk_abort_irq: assert property (evTargetAbortSent |=> pciErrInt)
        else $error("target abort left the interrupt low");
    chk_serr_drive: assert property (evAddrParErr |=> !serrPinOe_b)
        else $error("serr not driven after address parity error");
    chk_serr_low: assert property (!serrPinOe_b |-> !serrPinOut)
        else $error("serr driven high");
    chk_flag_hold: assert property (pciErrInt && !regWr |=> pciErrInt)
        else $error("interrupt dropped without a write");
    chk_burst_gate: assert property (cmdValid |-> cmdData.burstEn == (latV_reg[7:2] != 6'h00))
        else $error("burst enable does not follow latency timer");
    chk_short_read: assert property (cmdValid && cmdData.code == CMD_MEM_READ
        |-> lineSz_reg == 8'h00 || cmdData.words < {8'h00, lineSz_reg})
        else $error("plain read used for a full line");
    chk_winv_line: assert property (cmdValid && cmdData.code == CMD_MEM_WR_INV
        |-> lineSz_reg != 8'h00 && cmdData.words >= {8'h00, lineSz_reg})
        else $error("write invalidate shorter than a line");
    chk_accept_cmd: assert property (reqValid && reqReady |=> cmdValid ##1 !cmdValid)
        else $error("accepted request gave no single command");
    chk_done_resp: assert property (xferDone && !reqReady && !cmdValid
        |=> rspValid && !rspData.busErr)
        else $error("completed attempt gave no clean response");
    cover property (rspValid && rspData.busErr);
    cover property (cmdValid && cmdData.code == CMD_MEM_READ_MUL);
    cover property (!serrPinOe_b);
endmodule : pesr_bridge_props

//--- tb/pesr_engine_model.sv
// far side model: answers each attempt with done, disconnect or a trdy stall
`timescale 1ns/10ps
module pesr_engine_model
(
    input wire logic        mclk,
    input wire logic        rst_b,
    input wire logic        cmdValid,
    input wire logic [1:0]  engMode,
    output logic            xferDone,
    output logic            xferDisc,
    output logic [31:0]     xferData,
    output logic            trdyPin_b,
    output logic            drainIdle
);
    logic [3:0] cnt_reg;
    logic [2:0] drn_reg;
    // mode 2 never answers, so only the bridge's own timeout can end it
    wire        running = cnt_reg != 4'h0 && engMode != 2'h2;
    assign trdyPin_b = !running;
    assign drainIdle = drn_reg == 3'h0;
    always_ff @(posedge mclk or negedge rst_b)
        if (!rst_b)
        begin
            {cnt_reg, drn_reg, xferDone, xferDisc} <= 9'h000;
            xferData <= 32'h0000_0000;
        end
        else
        begin
            xferDone <= running && cnt_reg == 4'h1 && engMode == 2'h0;
            xferDisc <= running && cnt_reg == 4'h1 && engMode == 2'h1;
            xferData <= (running && cnt_reg == 4'h1) ? 32'hA5C3_0F17 : ~xferData;
            cnt_reg  <= cmdValid ? 4'h3 : (running ? cnt_reg - 4'h1 : cnt_reg);
            // a disconnect leaves traffic outstanding for a few cycles
            drn_reg  <= xferDisc ? 3'h4 : (drainIdle ? 3'h0 : drn_reg - 3'h1);
        end
endmodule : pesr_engine_model

//--- tb/tb_pesr_bridge.sv
// testbench: register, event, command, retry and timeout scenarios
`timescale 1ns/10ps
module tb_pesr_bridge;
    import pesr_pkg::*;
    logic        mclk, rst_b, regWr, regRd, pciClk, trdyPin_b, serrPinOut, serrPinOe_b;
    logic        evTargetAbortSent, evTargetAbortRcvd, evMasterAbort, evSpecialCycle;
    logic        evAddrParErr, evDataParErr, reqValid, reqReady, rspValid, cmdValid;
    logic        xferDone, xferDisc, drainIdle, pciErrInt;
    logic [7:0]  regAddr;
    logic [31:0] regWrData, regRdData, xferData;
    logic [5:0]  ev;
    logic [1:0]  engMode;
    pesr_req_t   reqData;
    pesr_rsp_t   rspData;
    pesr_cmd_t   cmdData;
    int          err_total, checks_done, nCmd, i;
    logic [5:0]  evTab [6] = '{6'h01, 6'h02, 6'h04, 6'h0C, 6'h10, 6'h20};
    logic [31:0] stTab [6] = '{32'h0800_0000, 32'h1000_0000, 32'h2000_0000, 32'h0,
                               32'hC000_0000, 32'h8000_0000};
    logic [31:0] ctlTab [3] = '{32'h0138, 32'h0338, 32'h0328};
    logic [15:0] expTab [3] = '{16'h0366, 16'h0566, 16'h0366};
    assign {evDataParErr, evAddrParErr, evSpecialCycle, evMasterAbort, evTargetAbortRcvd,
            evTargetAbortSent} = ev;

    pesr_bridge DUT (.*);
    pesr_engine_model u_engine (.*);

    initial
    begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    initial
    begin
        pciClk = 1'b0;
        #3;
        forever #80 pciClk = ~pciClk;
    end
    always @(negedge mclk)
        if (cmdValid === 1'b1)
            nCmd++;

    // ==================================================================
    // access tasks
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge mclk);
        regWr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge mclk);
        regRd <= 1'b0;
        @(negedge mclk);
        chk(regRdData, e);
    endtask : rd
    task pulse(input logic [5:0] v);
        @(posedge mclk);
        ev <= v;
        @(posedge mclk);
        ev <= 6'h00;
    endtask : pulse
    // packs attempts, burst, bus error, discard and command code into one word
    task xact(input logic w, input logic [31:0] a, input logic [15:0] n, input logic [15:0] e);
        int k;
        @(posedge mclk);
        reqValid <= 1'b1;
        reqData  <= '{w, a, n};
        nCmd = 0;
        @(posedge mclk);
        reqValid <= 1'b0;
        for (k = 0; k < 3000; k++)
        begin
            @(negedge mclk);
            if (rspValid === 1'b1)
                break;
        end
        // a response that never comes is a mismatch in its own right
        if (k == 3000)
            err_total++;
        chk({16'h0, nCmd[7:0], 1'b0, cmdData.burstEn, rspData.busErr, rspData.discarded,
             cmdData.code}, {16'h0, e});
    endtask : xact
    task results;
        $display("checks_done=%0d err_total=%0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : results

    // ==================================================================
    // scenarios
    initial
    begin
        {rst_b, regWr, regRd, regAddr, regWrData, ev, engMode, reqValid} = '0;
        reqData = '0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_LINE, 32'h0);
        rd(ADDR_LIMITS, 32'h8080);
        rd(ADDR_CTRL, 32'h0130);
        rd(ADDR_ERR, 32'h0);
        rd(8'h10, 32'h0);
        wr(ADDR_LINE, 32'h0000_FFFF);
        rd(ADDR_LINE, 32'h0000_FCFF);
        for (i = 0; i < 6; i++)
        begin
            pulse(evTab[i]);
            rd(ADDR_STATUS, stTab[i]);
            chk(pciErrInt, {31'h0, stTab[i][30:27] != 4'h0});
            wr(ADDR_STATUS, 32'hFFFF_0000);
            rd(ADDR_STATUS, 32'h0);
        end
        wr(ADDR_LINE, 32'h0000_0004);
        wr(ADDR_CTRL, 32'h0000_0132);
        xact(1'b0, 32'h0, 16'd3, 16'h0106);
        xact(1'b0, 32'h0, 16'd4, 16'h010E);
        xact(1'b0, 32'h0, 16'd8, 16'h010C);
        xact(1'b1, 32'h0, 16'd4, 16'h010F);
        xact(1'b1, 32'h4, 16'd4, 16'h0107);
        xact(1'b1, 32'h0, 16'd3, 16'h0107);
        wr(ADDR_LINE, 32'h0000_0804);
        xact(1'b0, 32'h0, 16'd1, 16'h0146);
        @(posedge mclk);
        engMode <= 2'h1;
        wr(ADDR_LIMITS, 32'h0000_0210);
        for (i = 0; i < 3; i++)
        begin
            wr(ADDR_CTRL, ctlTab[i]);
            xact(1'b0, 32'h0, 16'd1, expTab[i]);
            rd(ADDR_ERR, 32'h2);
            wr(ADDR_ERR, 32'h3);
        end
        wr(ADDR_CTRL, 32'h0130);
        xact(1'b1, 32'h0, 16'd1, 16'h0277);
        rd(ADDR_ERR, 32'h0);
        @(posedge mclk);
        engMode <= 2'h2;
        wr(ADDR_LIMITS, 32'h0000_0202);
        xact(1'b0, 32'h0, 16'd1, 16'h0166);
        rd(ADDR_ERR, 32'h0);
        chk(pciErrInt, 32'h0);
        wr(ADDR_CTRL, 32'h0134);
        xact(1'b0, 32'h0, 16'd1, 16'h0166);
        rd(ADDR_ERR, 32'h1);
        chk(pciErrInt, 32'h1);
        wr(ADDR_ERR, 32'h1);
        wr(ADDR_CTRL, 32'h0131);
        pulse(6'h20);
        // the flag lands at the edge that ends the pulse, so look half a cycle on
        @(negedge mclk);
        chk(pciErrInt, 32'h1);
        results();
    end
    initial
    begin
        #400000;
        err_total++;
        results();
    end
endmodule : tb_pesr_bridge

bind pesr_bridge pesr_bridge_props u_props (.*);
